/* smp_net_model.sv */
// Purpose: Network engine stand-in facing the standalone port logic
// Assumes: Driven just after the rising edge of clk
// Notes: Idle fields carry inverted leftovers so nothing stale looks valid
module smp_net_model
  import smp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Engine outputs
  output smp_pkg::smp_rx_t rx_out,
  output logic token_out,
  // Send requests
  input wire smp_pkg::smp_tx_t tx_in,
  output logic [7:0] tx_count
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_out = '0;
    token_out = 1'b0;
    tx_count = 8'h00;
  end

  always @(posedge clk) begin
    if (tx_in.req === 1'b1) begin
      tx_count <= tx_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // One-cycle pulses
  // ----------------------------------------------------------------
  task automatic send_rx(input logic [4:0] dest, input logic crc, input logic [15:0] a,
                         input logic [15:0] b);
    @(posedge clk);
    rx_out <= '{valid: 1'b1, crc_ok: crc, dest_id: dest, word_a: a, word_b: b};
    @(posedge clk);
    rx_out <= '{valid: 1'b0, crc_ok: ~crc, dest_id: ~dest, word_a: ~a, word_b: ~b};
  endtask

  task automatic send_token();
    @(posedge clk);
    token_out <= 1'b1;
    @(posedge clk);
    token_out <= 1'b0;
  endtask
endmodule

/* smp_pkg.sv */
// Purpose: Shared constants and carrier types for the standalone pin configuration block
// Assumes: 25 MHz clk, active-low asynchronous reset
// Notes: Register offsets belong to the peripheral-mode register window
package smp_pkg;
  // ----------------------------------------------------------------
  // Register map (peripheral mode only)
  // ----------------------------------------------------------------
  localparam logic [3:0] SMP_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SMP_ADDR_NODE = 4'h1;
  localparam logic [3:0] SMP_ADDR_STAT = 4'h2;
  localparam logic [3:0] SMP_ADDR_GPIO = 4'h3;
  localparam int SMP_CTRL_TRANSMIT_ENABLE_BIT_BIT = 0;
  localparam logic SMP_TRANSMIT_ENABLE_BIT_RST_PERIPH = 1'b0;
  localparam logic SMP_TRANSMIT_ENABLE_BIT_RST_STANDALONE = 1'b1;
  localparam logic [4:0] SMP_NODE_RST = 5'h01;
  localparam logic [15:0] SMP_GPIO_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Trigger modes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SMP_TRIG_TOKEN = 3'h5;
  localparam logic [2:0] SMP_TRIG_RSVD = 3'h6;
  localparam logic [2:0] SMP_TRIG_EXT = 3'h7;
  localparam int SMP_CLK_HZ = 25000000;
  localparam int SMP_TICK_NS = 1000;
  localparam int SMP_TICK_CYC = (SMP_CLK_HZ / 1000) * SMP_TICK_NS / 1000000;
  localparam int SMP_BASE_TICKS = 1600;

  typedef enum logic [1:0] {
    SMP_ST_RESET = 2'b00,
    SMP_ST_PERIPH = 2'b01,
    SMP_ST_ALONE = 2'b10
  } smp_state_t;

  typedef struct packed {
    logic [4:0] own_node_identifier;
    logic [2:0] send_trigger_select;
    logic [3:0] time_sync_config;
    logic line_error_mode;
  } smp_strap_t;

  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic [4:0] dest_id;
    logic [15:0] word_a;
    logic [15:0] word_b;
  } smp_rx_t;

  typedef struct packed {
    logic req;
    logic [15:0] data;
  } smp_tx_t;
endpackage

/* smp_sync.sv */
// Purpose: Two-stage synchroniser for a bus of pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes: First stage feeds only the second stage
module smp_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* smp_top.sv */
// Purpose: Mode strap, pin repurposing and standalone port logic
// Assumes: Network engine supplies rx results and takes tx requests on clk
// Notes: Pin functions are fixed from mode selection, three edges after reset release, until the next reset
// Contract
// - A low standalone select strap picks processor-less mode, high picks peripheral mode.
// - In standalone mode sends are started here without any host command.
// - In standalone mode host reads and writes never touch the registers.
// - In standalone mode the transmit enable resets to one.
// - In standalone mode the node identifier and trigger setup come from strap pins.
// - In standalone mode the host data lines are inputs only forming the input port.
// - Output port bits 15 to 8 float in peripheral mode and drive in standalone mode once a good addressed packet has latched.
// - In standalone mode the strobe and address pins drive output port bits 7 to 0.
// - In standalone mode the host control inputs are node identifier straps 4 to 0.
// - In standalone mode the sampled input port is sent as a broadcast packet.
// - The standalone output port floats after reset until a good addressed packet latches.
module smp_top
  import smp_pkg::*;
#(
  parameter int TIMER_TICKS = SMP_BASE_TICKS * SMP_TICK_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Mode strap
  input wire logic processorless_select_n,
  // Host data pins / parallel input port
  input wire logic [15:0] data_pin_in,
  output logic [15:0] data_pin_out,
  output logic [15:0] data_pin_oe,
  // Host strobe and address pins / parallel output port low byte
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [5:0] addr_pin_in,
  output logic [7:0] po_low_out,
  output logic [7:0] po_low_oe,
  // Parallel output port high byte
  output logic [7:0] po_high_out,
  output logic [7:0] po_high_oe,
  // Host control pins / node identifier straps
  input wire logic chip_select_n,
  input wire logic byte_swap_n,
  input wire logic wide_bus_select,
  input wire logic rw_mode_n,
  input wire logic address_mux_n,
  // Other shared straps
  input wire logic [2:0] prescale_pins,
  input wire logic [3:0] time_sync_config,
  input wire logic strobe_invert_n,
  // Network engine side
  input wire smp_pkg::smp_rx_t rx_in,
  input wire logic token_rx,
  input wire logic time_sync_unlock,
  input wire logic host_irq,
  output smp_pkg::smp_tx_t tx_out,
  output logic transmit_enable_bit,
  output logic standalone_mode,
  output smp_pkg::smp_strap_t strap_out,
  output logic [4:0] own_node_identifier,
  output logic host_interrupt_n
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [37:0] pins_raw;
  logic [37:0] pins_s;
  assign pins_raw = {time_sync_config, strobe_invert_n, processorless_select_n, data_pin_in,
                     write_strobe_n, read_strobe_n, addr_pin_in, chip_select_n, byte_swap_n,
                     wide_bus_select, rw_mode_n, address_mux_n, prescale_pins};

  smp_sync #(.W(38)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .din(pins_raw),
    .dout(pins_s)
  );

  logic sel_n_s;
  logic [15:0] pi_s;
  logic wr_n_s;
  logic rd_n_s;
  logic [5:0] addr_s;
  logic [4:0] scm_s;
  logic [2:0] pre_s;
  logic [3:0] tsc_s;
  logic inv_s;
  assign tsc_s = pins_s[37:34];
  assign inv_s = pins_s[33];
  assign sel_n_s = pins_s[32];
  assign pi_s = pins_s[31:16];
  assign wr_n_s = pins_s[15];
  assign rd_n_s = pins_s[14];
  assign addr_s = pins_s[13:8];
  assign scm_s = pins_s[7:3];
  assign pre_s = pins_s[2:0];

  // ----------------------------------------------------------------
  // Mode latch
  // ----------------------------------------------------------------
  // Strap is sync'd first, so the mode settles three edges after release
  smp_state_t state_q;
  logic [1:0] settle_q;
  logic alone;
  assign alone = (state_q == SMP_ST_ALONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SMP_ST_RESET;
      settle_q <= 2'h0;
    end else if (ce) begin
      case (state_q)
        SMP_ST_RESET: begin
          if (settle_q == 2'h2) begin
            state_q <= sel_n_s ? SMP_ST_PERIPH : SMP_ST_ALONE;
          end else begin
            settle_q <= settle_q + 2'h1;
          end
        end
        SMP_ST_PERIPH: state_q <= SMP_ST_PERIPH;
        SMP_ST_ALONE: state_q <= SMP_ST_ALONE;
        default: state_q <= SMP_ST_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers (peripheral mode host access)
  // ----------------------------------------------------------------
  logic wr_d1_q;
  logic rd_d1_q;
  logic wr_pulse;
  logic rd_pulse;
  logic transmit_enable_bit_q;
  logic [4:0] node_q;
  logic [15:0] gpio_q;
  logic mode_seen_q;
  assign wr_pulse = wr_d1_q && !wr_n_s;
  assign rd_pulse = rd_d1_q && !rd_n_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Sync stages reset low, so history starts low too: no false strobe edge
      wr_d1_q <= 1'b0;
      rd_d1_q <= 1'b0;
    end else if (ce) begin
      wr_d1_q <= wr_n_s;
      rd_d1_q <= rd_n_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_enable_bit_q <= SMP_TRANSMIT_ENABLE_BIT_RST_PERIPH;
      node_q <= SMP_NODE_RST;
      gpio_q <= SMP_GPIO_RST;
      mode_seen_q <= 1'b0;
    end else if (ce) begin
      if (state_q != SMP_ST_RESET && !mode_seen_q) begin
        mode_seen_q <= 1'b1;
        if (alone) begin
          transmit_enable_bit_q <= SMP_TRANSMIT_ENABLE_BIT_RST_STANDALONE;
        end
      end else if (!alone && state_q == SMP_ST_PERIPH && wr_pulse && !scm_s[4]) begin
        // Host writes are gated off entirely in standalone mode
        case (addr_s[3:0])
          SMP_ADDR_CTRL: transmit_enable_bit_q <= pi_s[SMP_CTRL_TRANSMIT_ENABLE_BIT_BIT];
          SMP_ADDR_NODE: node_q <= pi_s[4:0];
          SMP_ADDR_GPIO: gpio_q <= pi_s;
          default: ;
        endcase
      end
    end
  end

  logic [15:0] rdata;
  always_comb begin
    case (addr_s[3:0])
      SMP_ADDR_CTRL: rdata = {15'h0000, transmit_enable_bit_q};
      SMP_ADDR_NODE: rdata = {11'h000, node_q};
      SMP_ADDR_STAT: rdata = {14'h0000, state_q};
      SMP_ADDR_GPIO: rdata = gpio_q;
      default: rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Straps and data bus pins
  // ----------------------------------------------------------------
  logic [4:0] strap_id_q;
  logic [2:0] trig_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_id_q <= 5'h00;
      trig_q <= 3'h0;
      data_pin_out <= 16'h0000;
      data_pin_oe <= 16'h0000;
      strap_out <= '0;
      own_node_identifier <= 5'h00;
      transmit_enable_bit <= 1'b0;
      standalone_mode <= 1'b0;
      host_interrupt_n <= 1'b1;
    end else if (ce) begin
      if (state_q == SMP_ST_RESET) begin
        strap_id_q <= scm_s;
        trig_q <= pre_s;
      end
      if (alone) begin
        data_pin_oe <= 16'h0000;
        own_node_identifier <= strap_id_q;
      end else begin
        data_pin_oe <= (state_q == SMP_ST_PERIPH && rd_pulse && !scm_s[4]) ? 16'hFFFF : 16'h0000;
        data_pin_out <= rdata;
        own_node_identifier <= node_q;
      end
      strap_out <= '{own_node_identifier: strap_id_q, send_trigger_select: trig_q,
                     time_sync_config: tsc_s, line_error_mode: inv_s};
      transmit_enable_bit <= transmit_enable_bit_q;
      standalone_mode <= alone;
      host_interrupt_n <= alone ? !time_sync_unlock : !host_irq;
    end
  end

  // ----------------------------------------------------------------
  // Standalone send triggering
  // ----------------------------------------------------------------
  // Timer base is the shortest period; longer settings shift it left by strap bits 1 to 0
  logic [31:0] tmr_q;
  logic [31:0] tmr_lim;
  logic pistr_d_q;
  logic trig_fire;
  logic rx_good;
  assign tmr_lim = 32'(TIMER_TICKS) << trig_q[1:0];
  assign rx_good = rx_in.valid && rx_in.crc_ok && rx_in.dest_id == own_node_identifier;

  always_comb begin
    case (trig_q)
      SMP_TRIG_TOKEN: trig_fire = token_rx;
      SMP_TRIG_RSVD: trig_fire = 1'b0;
      SMP_TRIG_EXT: trig_fire = pistr_d_q && !pi_s[0];
      default: trig_fire = rx_good || (tmr_q >= tmr_lim - 32'h1);
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= 32'h0;
      pistr_d_q <= 1'b1;
      tx_out <= '0;
    end else if (ce) begin
      pistr_d_q <= pi_s[0];
      tmr_q <= (!alone || trig_fire) ? 32'h0 : tmr_q + 32'h1;
      tx_out.req <= alone && transmit_enable_bit_q && trig_fire;
      if (alone && trig_fire) begin
        tx_out.data <= (trig_q == SMP_TRIG_EXT) ? {pi_s[15:1], 1'b0} : pi_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standalone output port
  // ----------------------------------------------------------------
  logic po_valid_q;
  logic rx_latch;
  assign rx_latch = alone && rx_good && rx_in.word_a == rx_in.word_b;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      po_valid_q <= 1'b0;
      po_high_out <= 8'h00;
      po_high_oe <= 8'h00;
      po_low_out <= 8'h00;
      po_low_oe <= 8'h00;
    end else if (ce) begin
      if (rx_latch) begin
        po_valid_q <= 1'b1;
        po_high_out <= rx_in.word_a[15:8];
        po_low_out <= rx_in.word_a[7:0];
        if (trig_q == SMP_TRIG_EXT) begin
          po_low_out[0] <= 1'b0;
        end
      end else if (trig_q == SMP_TRIG_EXT) begin
        po_low_out[0] <= 1'b1;
      end
      po_high_oe <= (alone && (po_valid_q || rx_latch)) ? 8'hFF : 8'h00;
      po_low_oe <= (alone && (po_valid_q || rx_latch)) ? 8'hFF : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MODE_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q != SMP_ST_RESET) |=> $stable(state_q))
    else $error("mode changed after selection");
  sequence s_mode_pick;
    state_q == SMP_ST_RESET && settle_q == 2'h2 && ce;
  endsequence
  AST_SEL_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    (s_mode_pick ##0 !sel_n_s) |=> alone)
    else $error("low strap did not select standalone");
  AST_SEL_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    (s_mode_pick ##0 sel_n_s) |=> state_q == SMP_ST_PERIPH)
    else $error("high strap did not select peripheral");
  AST_NO_REG_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (alone && mode_seen_q) |=> $stable(node_q) && $stable(gpio_q))
    else $error("register changed in standalone mode");
  AST_TRANSMIT_ENABLE_BIT_ON: assert property (@(posedge clk) disable iff (!rst_n)
    (alone && mode_seen_q) |-> transmit_enable_bit_q)
    else $error("transmit enable not set in standalone");
  AST_DATA_IN: assert property (@(posedge clk) disable iff (!rst_n)
    alone ##1 ce |=> data_pin_oe == 16'h0000)
    else $error("data pins driven in standalone");
  AST_PO_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
    !po_valid_q && !rx_latch |=> po_high_oe == 8'h00 && po_low_oe == 8'h00)
    else $error("output port driven before first packet");
  AST_PO_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_latch && ce) |=> po_high_out == $past(rx_in.word_a[15:8]) && po_high_oe == 8'hFF
    && po_low_out[7:1] == $past(rx_in.word_a[7:1]) && po_low_oe == 8'hFF)
    else $error("output port not latched");
  AST_SEND: assert property (@(posedge clk) disable iff (!rst_n)
    (alone && transmit_enable_bit_q && trig_fire && ce) |=> tx_out.req)
    else $error("send not requested");
  AST_ID_STRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (alone && ce) |=> own_node_identifier == $past(strap_id_q))
    else $error("node id not from straps");
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the mode strap and pin repurposing block
// Assumes: 25 MHz clk, TIMER_TICKS shortened to 20
// Notes: Host write strobes are held 4 cycles, read strobes 8, with 3 idle cycles after each
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import smp_pkg::*;

  localparam logic [15:0] PI_VAL = 16'hA5C3;
  localparam logic [15:0] PI_EXT = {PI_VAL[15:1], 1'b0};
  localparam logic [4:0] STRAP_ID = 5'h13;
  logic clk = 1'b0, rst_n = 1'b0, processorless_select_n = 1'b1;
  logic [15:0] data_pin_in = 16'h0000, data_pin_out, data_pin_oe, rd;
  logic write_strobe_n = 1'b1, read_strobe_n = 1'b1, seen;
  logic [5:0] addr_pin_in = 6'h00;
  logic [7:0] po_low_out, po_low_oe, po_high_out, po_high_oe, tx_count, n;
  logic chip_select_n = 1'b0, byte_swap_n = 1'b0, wide_bus_select = 1'b1;
  logic rw_mode_n = 1'b1, address_mux_n = 1'b1, strobe_invert_n = 1'b1;
  logic [2:0] prescale_pins = 3'h1;
  logic [3:0] time_sync_config = 4'hA;
  logic token_rx, time_sync_unlock = 1'b0, host_irq = 1'b0;
  logic transmit_enable_bit, standalone_mode, host_interrupt_n;
  logic [4:0] own_node_identifier;
  smp_rx_t rx_in;
  smp_tx_t tx_out;
  smp_strap_t strap_out;
  int err_count = 0;
  int check_count = 0;

  smp_top #(.TIMER_TICKS(20)) i_dut (.clk, .rst_n, .ce(1'b1), .processorless_select_n,
    .data_pin_in, .data_pin_out, .data_pin_oe, .write_strobe_n, .read_strobe_n, .addr_pin_in,
    .po_low_out, .po_low_oe, .po_high_out, .po_high_oe, .chip_select_n, .byte_swap_n,
    .wide_bus_select, .rw_mode_n, .address_mux_n, .prescale_pins, .time_sync_config,
    .strobe_invert_n, .rx_in, .token_rx, .time_sync_unlock, .host_irq, .tx_out,
    .transmit_enable_bit, .standalone_mode, .strap_out, .own_node_identifier, .host_interrupt_n);
  smp_net_model i_net (.clk, .rx_out(rx_in), .token_out(token_rx), .tx_in(tx_out), .tx_count);

  initial begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare, reset and host tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset(input logic sel, input logic [2:0] pre);
    @(posedge clk);
    rst_n <= 1'b0;
    processorless_select_n <= sel;
    prescale_pins <= pre;
    data_pin_in <= PI_VAL;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic host_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr_pin_in <= a;
    data_pin_in <= d;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Read data is taken in whichever cycle the pins are driven
  task automatic host_rd(input logic [5:0] a, output logic [15:0] d, output logic s);
    d = 'x;
    s = 1'b0;
    @(posedge clk);
    addr_pin_in <= a;
    read_strobe_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (data_pin_oe !== 16'h0000) s = 1'b1;
      if (data_pin_oe[0] === 1'b1) d = data_pin_out;
    end
    read_strobe_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Looked at mid-cycle, where the registered request stands settled
  always @(negedge clk) begin
    if (standalone_mode === 1'b1 && tx_out.req === 1'b1) begin
      chk_val(tx_out.data, (prescale_pins == SMP_TRIG_EXT) ? PI_EXT : PI_VAL);
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b1, 3'h1);
    chk_flag(standalone_mode, 1'b0);
    chk_val({po_high_oe, po_low_oe}, 16'h0000);
    chk_flag(transmit_enable_bit, SMP_TRANSMIT_ENABLE_BIT_RST_PERIPH);
    host_rd({2'b00, SMP_ADDR_CTRL}, rd, seen);
    chk_flag(rd[SMP_CTRL_TRANSMIT_ENABLE_BIT_BIT], SMP_TRANSMIT_ENABLE_BIT_RST_PERIPH);
    host_rd({2'b00, SMP_ADDR_NODE}, rd, seen);
    chk_val({11'h000, rd[4:0]}, {11'h000, SMP_NODE_RST});
    host_wr({2'b00, SMP_ADDR_NODE}, 16'h000A);
    host_rd({2'b00, SMP_ADDR_NODE}, rd, seen);
    chk_val({11'h000, rd[4:0]}, 16'h000A);
    host_rd(6'h3F, rd, seen);
    chk_val(data_pin_oe, 16'h0000);
    host_irq <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_flag(host_interrupt_n, 1'b0);
    host_irq <= 1'b0;
    $display("test peripheral done");

    {chip_select_n, byte_swap_n, wide_bus_select, rw_mode_n, address_mux_n} <= STRAP_ID;
    strobe_invert_n <= 1'b0;
    time_sync_unlock <= 1'b1;
    do_reset(1'b0, 3'h1);
    chk_flag(standalone_mode, 1'b1);
    chk_flag(transmit_enable_bit, 1'b1);
    chk_val({11'h000, own_node_identifier}, {11'h000, STRAP_ID});
    chk_val({11'h000, strap_out.own_node_identifier}, {11'h000, STRAP_ID});
    chk_val({12'h000, strap_out.time_sync_config}, 16'h000A);
    chk_flag(strap_out.line_error_mode, 1'b0);
    chk_val({13'h0000, strap_out.send_trigger_select}, 16'h0001);
    host_wr({2'b00, SMP_ADDR_NODE}, PI_VAL);
    host_rd({2'b00, SMP_ADDR_NODE}, rd, seen);
    chk_flag(seen, 1'b0);
    chk_val(data_pin_oe, 16'h0000);
    chk_val({11'h000, own_node_identifier}, {11'h000, STRAP_ID});
    chk_val({po_high_oe, po_low_oe}, 16'h0000);
    i_net.send_rx(STRAP_ID ^ 5'h01, 1'b1, 16'h1234, 16'h1234);
    i_net.send_rx(STRAP_ID, 1'b0, 16'h1234, 16'h1234);
    i_net.send_rx(STRAP_ID, 1'b1, 16'h1234, 16'h4321);
    repeat (3) @(posedge clk);
    #1;
    chk_val({po_high_oe, po_low_oe}, 16'h0000);
    n = tx_count;
    i_net.send_rx(STRAP_ID, 1'b1, 16'h5AC3, 16'h5AC3);
    #1;
    chk_val({po_high_oe, po_low_oe}, 16'hFFFF);
    chk_val({po_high_out, po_low_out}, 16'h5AC3);
    repeat (2) @(posedge clk);
    #1;
    chk_flag(tx_count != n, 1'b1);
    processorless_select_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk_flag(standalone_mode, 1'b1);
    chk_val({po_high_out, po_low_out}, 16'h5AC3);
    $display("test standalone rx done");

    do_reset(1'b0, SMP_TRIG_TOKEN);
    chk_val({po_high_oe, po_low_oe}, 16'h0000);
    n = tx_count;
    repeat (60) @(posedge clk);
    #1;
    chk_val({8'h00, tx_count}, {8'h00, n});
    i_net.send_token();
    repeat (3) @(posedge clk);
    #1;
    chk_val({8'h00, tx_count}, {8'h00, n + 8'h01});
    $display("test standalone token done");

    do_reset(1'b0, SMP_TRIG_EXT);
    n = tx_count;
    data_pin_in <= PI_VAL & 16'hFFFE;
    repeat (2) @(posedge clk);
    data_pin_in <= PI_VAL;
    repeat (6) @(posedge clk);
    #1;
    chk_val({8'h00, tx_count}, {8'h00, n + 8'h01});
    $display("test standalone strobe done");
    finish_test();
  end
endmodule
